// ===== p6bc_defines.svh
// register indices, reset values, field positions and bus constants for port six
`ifndef P6BC_DEFINES_SVH
`define P6BC_DEFINES_SVH
// register indices; byte address is four times the index
`define P6BC_DDR_IDX 16'hFFC9
`define P6BC_DR_IDX 16'hFFCB
`define P6BC_BRC_IDX 16'hFFF0
`define P6BC_WCE_IDX 16'hFFF1
`define P6BC_WCR_IDX 16'hFFF2
// reset values
`define P6BC_DDR_RST_LOW 8'hF8
`define P6BC_DDR_RST_HIGH 8'h80
`define P6BC_DR_RST 8'h80
`define P6BC_WCE_RST 8'hFF
`define P6BC_BRC_RST 8'h00
`define P6BC_WCR_RST 8'h00
`define P6BC_DDR_READ 8'hFF
// field positions
`define P6BC_BUS_RELEASE_ENABLE_BIT 0
`define P6BC_WAIT_MODE_SELECT_HIGH_BIT 1
// operating modes
`define P6BC_MODE_SINGLE 3'h7
`define P6BC_MODE_HIGH_DDR 3'h6
// axi responses
`define P6BC_RESP_OKAY 2'h0
`define P6BC_RESP_DECERR 2'h3
`endif

// ===== p6bc_pkg.sv
// types and shared decode functions for the port six block
`include "p6bc_defines.svh"
package p6bc_pkg;
    // bus controller strobes feeding the shared pins, active low
    typedef struct packed {
        logic low_byte_write_strobe_n;
        logic high_byte_write_strobe_n;
        logic read_strobe_n;
        logic address_strobe_n;
        logic bus_grant_ack_n;
    } p6bc_bus_ctl_t;
    // per-pin drive value and enable
    typedef struct packed {
        logic [6:0] out;
        logic [6:0] oe;
    } p6bc_pins_t;
    // function selection inputs of the pin mux
    typedef struct packed {
        logic expanded;
        logic bus_release_enable;
        logic wait_pin_free;
    } p6bc_sel_t;
    // register selected by an address
    typedef enum logic [2:0] {
        P6BC_SEL_NONE = 3'h0,
        P6BC_SEL_DDR = 3'h1,
        P6BC_SEL_DR = 3'h2,
        P6BC_SEL_BRC = 3'h3,
        P6BC_SEL_WCE = 3'h4,
        P6BC_SEL_WCR = 3'h5
    } p6bc_reg_sel_t;
    // expanded modes are all but single-chip
    function automatic logic p6bc_is_expanded(input logic [2:0] mode);
        return mode != `P6BC_MODE_SINGLE;
    endfunction : p6bc_is_expanded
    // direction reset value by mode
    function automatic logic [7:0] p6bc_ddr_init(input logic [2:0] mode);
        return (mode >= `P6BC_MODE_HIGH_DDR) ? `P6BC_DDR_RST_HIGH : `P6BC_DDR_RST_LOW;
    endfunction : p6bc_ddr_init
    // word address decode, upper bits must be zero
    function automatic p6bc_reg_sel_t p6bc_decode(input logic [31:0] addr);
        p6bc_reg_sel_t sel;
        sel = P6BC_SEL_NONE;
        if (addr[31:18] == 14'h0000)
        begin
            case (addr[17:2])
                `P6BC_DDR_IDX: sel = P6BC_SEL_DDR;
                `P6BC_DR_IDX: sel = P6BC_SEL_DR;
                `P6BC_BRC_IDX: sel = P6BC_SEL_BRC;
                `P6BC_WCE_IDX: sel = P6BC_SEL_WCE;
                `P6BC_WCR_IDX: sel = P6BC_SEL_WCR;
                default: sel = P6BC_SEL_NONE;
            endcase
        end
        return sel;
    endfunction : p6bc_decode
endpackage : p6bc_pkg

// ===== p6bc_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module p6bc_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg; // first stage, read only by the second
    // no reset: straps must flow through during reset
    always_ff @(posedge aclk)
    begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
endmodule : p6bc_sync

// ===== p6bc_pin_mux.sv
// pin function selection for the seven shared pins
`timescale 1ns/1ps
module p6bc_pin_mux
    import p6bc_pkg::*;
(
    input wire p6bc_sel_t sel,
    input wire logic [6:0] ddr,
    input wire logic [6:0] dr,
    input wire p6bc_bus_ctl_t bus_ctl,
    input wire logic [6:0] pin_level,
    output p6bc_pins_t pins,
    output logic bus_request_n,
    output logic wait_request_n
);
    // plain port by direction, then alternate functions override
    always_comb
    begin
        pins.out = dr;
        pins.oe = ddr;
        bus_request_n = 1'b1;
        wait_request_n = 1'b1;
        if (sel.expanded)
        begin
            // strobes own pins six to three
            pins.out[6] = bus_ctl.low_byte_write_strobe_n;
            pins.out[5] = bus_ctl.high_byte_write_strobe_n;
            pins.out[4] = bus_ctl.read_strobe_n;
            pins.out[3] = bus_ctl.address_strobe_n;
            pins.oe[6:3] = 4'hF;
            // bus release handshake
            if (sel.bus_release_enable)
            begin
                pins.out[2] = bus_ctl.bus_grant_ack_n;
                pins.oe[2] = 1'b1;
                pins.oe[1] = 1'b0;
                bus_request_n = pin_level[1];
            end
            // wait input unless every area waits by program and wait mode select high is clear
            if (!sel.wait_pin_free)
            begin
                pins.oe[0] = 1'b0;
                wait_request_n = pin_level[0];
            end
        end
    end
endmodule : p6bc_pin_mux

// ===== p6bc_top.sv
// port six register block with axi4-lite slave and shared pin control
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "p6bc_defines.svh"
module p6bc_top
    import p6bc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] mode_pins,
    input wire logic hw_standby_n,
    input wire logic sw_standby,
    input wire p6bc_bus_ctl_t bus_ctl,
    input wire logic [6:0] pin_in,
    output logic [6:0] pin_out,
    output logic [6:0] pin_oe,
    output logic bus_request_n,
    output logic wait_request_n
);
    logic [6:0] pin_s; // synchronised pin levels
    logic hw_standby_s_n; // synchronised standby pin
    logic [2:0] mode_s; // synchronised mode straps
    logic [2:0] mode_reg; // mode caught while reset is held
    logic [2:0] mode_now; // mode used for initial values
    logic hw_standby; // hardware standby active
    logic init; // reinitialise port registers
    logic [6:0] ddr_reg; // direction bits six to zero
    logic [6:0] dr_reg; // output data bits six to zero
    logic bus_release_enable_reg; // bus release enable
    logic [7:0] wce_reg; // per-area wait enables
    logic wait_mode_select_high_reg; // wait mode select high
    logic aw_held_reg; // write address taken
    logic w_held_reg; // write data taken
    logic [31:0] awaddr_reg; // held write address
    logic [31:0] wdata_reg; // held write data
    logic [3:0] wstrb_reg; // held write strobes
    logic bvalid_reg; // write response pending
    logic [1:0] bresp_reg; // write response code
    logic rvalid_reg; // read data pending
    logic [1:0] rresp_reg; // read response code
    logic [31:0] rdata_reg; // read data
    logic commit; // both halves of a write present
    logic wr_lane0; // low byte lane enabled
    p6bc_reg_sel_t wr_sel; // target of the held write
    p6bc_reg_sel_t rd_sel; // target of the offered read
    logic [31:0] rdata_next; // read data for the offered read
    p6bc_sel_t mux_sel; // function selection
    p6bc_pins_t mux_pins; // pin drive from the mux
    logic mux_req_n; // bus request from the mux
    logic mux_wait_n; // wait request from the mux
    logic [6:0] pin_out_reg; // registered pin drive
    logic [6:0] pin_oe_reg; // registered pin enables
    logic bus_request_n_reg; // registered bus request
    logic wait_request_n_reg; // registered wait request
    logic [7:0] ddr_init_val; // direction reset value for the current mode
    localparam logic [7:0] dr_init = `P6BC_DR_RST; // data reset value, sliceable
    localparam logic [7:0] brc_init = `P6BC_BRC_RST; // release control reset value
    localparam logic [7:0] wcr_init = `P6BC_WCR_RST; // wait control reset value

    // pins, standby and straps come from outside the clock domain
    p6bc_sync #(
        .W(11)
    ) u_sync (
        .aclk(aclk),
        .async_in({pin_in, hw_standby_n, mode_pins}),
        .sync_out({pin_s, hw_standby_s_n, mode_s})
    );

    assign hw_standby = !hw_standby_s_n;
    assign mode_now = aresetn ? mode_reg : mode_s;
    assign ddr_init_val = p6bc_ddr_init(mode_now);
    assign init = !aresetn || hw_standby;

    // operating mode follows the straps during reset, frozen afterwards
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_reg <= mode_s;
        end
    end

    // write decode
    assign commit = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_sel = p6bc_decode(awaddr_reg);
    assign wr_lane0 = wstrb_reg[0];

    // direction register, reinitialised by reset and hardware standby
    always_ff @(posedge aclk)
    begin
        if (init)
        begin
            ddr_reg <= ddr_init_val[6:0];
        end
        else if (commit && wr_lane0 && wr_sel == P6BC_SEL_DDR)
        begin
            ddr_reg <= wdata_reg[6:0]; // bit seven has no storage
        end
    end

    // data register, bit seven has no storage
    always_ff @(posedge aclk)
    begin
        if (init)
        begin
            dr_reg <= dr_init[6:0];
        end
        else if (commit && wr_lane0 && wr_sel == P6BC_SEL_DR)
        begin
            dr_reg <= wdata_reg[6:0];
        end
    end

    // bus release and wait control bits
    always_ff @(posedge aclk)
    begin
        if (init)
        begin
            bus_release_enable_reg <= brc_init[`P6BC_BUS_RELEASE_ENABLE_BIT];
            wce_reg <= `P6BC_WCE_RST;
            wait_mode_select_high_reg <= wcr_init[`P6BC_WAIT_MODE_SELECT_HIGH_BIT];
        end
        else if (commit && wr_lane0)
        begin
            if (wr_sel == P6BC_SEL_BRC)
            begin
                bus_release_enable_reg <= wdata_reg[`P6BC_BUS_RELEASE_ENABLE_BIT];
            end
            if (wr_sel == P6BC_SEL_WCE)
            begin
                wce_reg <= wdata_reg[7:0];
            end
            if (wr_sel == P6BC_SEL_WCR)
            begin
                wait_mode_select_high_reg <= wdata_reg[`P6BC_WAIT_MODE_SELECT_HIGH_BIT];
            end
        end
    end

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `P6BC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (commit)
            begin
                // response follows both halves
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_sel == P6BC_SEL_NONE) ? `P6BC_RESP_DECERR : `P6BC_RESP_OKAY;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // read data mux
    assign rd_sel = p6bc_decode(s_axi_araddr);
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (rd_sel)
            P6BC_SEL_DDR: rdata_next[7:0] = `P6BC_DDR_READ;
            P6BC_SEL_DR: rdata_next[7:0] = {1'b1, (dr_reg & ddr_reg) | (pin_s & ~ddr_reg)};
            P6BC_SEL_BRC: rdata_next[`P6BC_BUS_RELEASE_ENABLE_BIT] = bus_release_enable_reg;
            P6BC_SEL_WCE: rdata_next[7:0] = wce_reg;
            P6BC_SEL_WCR: rdata_next[`P6BC_WAIT_MODE_SELECT_HIGH_BIT] = wait_mode_select_high_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read channel: one read at a time, answer the next cycle
    assign s_axi_arready = !rvalid_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `P6BC_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdata_next;
            rresp_reg <= (rd_sel == P6BC_SEL_NONE) ? `P6BC_RESP_DECERR : `P6BC_RESP_OKAY;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // pin function selection
    assign mux_sel.expanded = p6bc_is_expanded(mode_reg);
    assign mux_sel.bus_release_enable = bus_release_enable_reg;
    assign mux_sel.wait_pin_free = (wce_reg == 8'hFF) && !wait_mode_select_high_reg;

    p6bc_pin_mux u_pin_mux (
        .sel(mux_sel),
        .ddr(ddr_reg),
        .dr(dr_reg),
        .bus_ctl(bus_ctl),
        .pin_level(pin_s),
        .pins(mux_pins),
        .bus_request_n(mux_req_n),
        .wait_request_n(mux_wait_n)
    );

    // registered pin drive; hardware standby floats, software standby holds
    always_ff @(posedge aclk)
    begin
        if (init)
        begin
            pin_out_reg <= 7'h7F;
            pin_oe_reg <= 7'h00;
            bus_request_n_reg <= 1'b1;
            wait_request_n_reg <= 1'b1;
        end
        else if (!sw_standby)
        begin
            pin_out_reg <= mux_pins.out;
            pin_oe_reg <= mux_pins.oe;
            bus_request_n_reg <= mux_req_n;
            wait_request_n_reg <= mux_wait_n;
        end
        // software standby: outputs keep their state
    end
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign bus_request_n = bus_request_n_reg;
    assign wait_request_n = wait_request_n_reg;

    // checks
    a_ddr_reads_ones: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_sel == P6BC_SEL_DDR |=> s_axi_rvalid && s_axi_rdata == 32'h0000_00FF)
        else $error("direction read not all ones");

    a_ddr_reset_value: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) && !hw_standby |-> {1'b1, ddr_reg} == p6bc_ddr_init(mode_reg))
        else $error("direction reset value wrong for mode");

    a_sw_standby_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sw_standby && !hw_standby && !commit |=> $stable(ddr_reg) && $stable(pin_oe) && $stable(pin_out))
        else $error("state changed in software standby");

    a_strobe_pins: assert property (
        @(posedge aclk) disable iff (!aresetn)
        mux_sel.expanded && !init && !sw_standby
        |=> pin_oe[6:3] == 4'hF && pin_out[6] == $past(bus_ctl.low_byte_write_strobe_n)
            && pin_out[3] == $past(bus_ctl.address_strobe_n))
        else $error("strobe pins not driven");

    a_single_chip_io: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !mux_sel.expanded && !init && !sw_standby |=> pin_oe == $past(ddr_reg) && pin_out == $past(dr_reg))
        else $error("single-chip pins not plain port");

    a_data_readback: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_sel == P6BC_SEL_DR
        |=> s_axi_rdata[6:0] == (($past(dr_reg) & $past(ddr_reg)) | ($past(pin_s) & ~$past(ddr_reg))))
        else $error("data read mixes pin and latch wrongly");

    a_data_bit7: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_sel == P6BC_SEL_DR |=> s_axi_rdata[31:7] == 25'h0000001)
        else $error("data bit seven not one");

    a_data_init: assert property (
        @(posedge aclk) disable iff (!aresetn)
        hw_standby |=> dr_reg == 7'h00 && pin_oe == 7'h00)
        else $error("hardware standby did not reinitialise");

    a_bus_release: assert property (
        @(posedge aclk) disable iff (!aresetn)
        mux_sel.expanded && bus_release_enable_reg && !init && !sw_standby
        |=> pin_oe[2:1] == 2'b10 && pin_out[2] == $past(bus_ctl.bus_grant_ack_n) && bus_request_n == $past(pin_s[1]))
        else $error("bus release pins wrong");

    a_wait_input: assert property (
        @(posedge aclk) disable iff (!aresetn)
        mux_sel.expanded && !mux_sel.wait_pin_free && !init && !sw_standby
        |=> !pin_oe[0] && wait_request_n == $past(pin_s[0]))
        else $error("wait pin not an input");
endmodule : p6bc_top

// ===== p6bc_ext_model.sv
// outside devices on the seven shared port pins
`timescale 1ns/1ps
module p6bc_ext_model (
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] ext_level,
    output logic [6:0] pin_in
);
    // resolve each wire: port drive wins, else the outside device level
    // pin1 carries the requester's bus request, pin0 the memory's wait request
    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule : p6bc_ext_model

// ===== tb_top.sv
// self-checking bench for the port six block over axi4-lite
`timescale 1ns/1ps
`include "p6bc_defines.svh"
module tb_top;
    import p6bc_pkg::*;
    // register byte addresses
    localparam logic [31:0] A_DDR = {14'h0000, `P6BC_DDR_IDX, 2'h0};
    localparam logic [31:0] A_DR = {14'h0000, `P6BC_DR_IDX, 2'h0};
    localparam logic [31:0] A_BRC = {14'h0000, `P6BC_BRC_IDX, 2'h0};
    localparam logic [31:0] A_WCE = {14'h0000, `P6BC_WCE_IDX, 2'h0};
    localparam logic [31:0] A_WCR = {14'h0000, `P6BC_WCR_IDX, 2'h0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd_word;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, bus_request_n, wait_request_n;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] mode_pins = 3'h7;
    logic hw_standby_n = 1'b1, sw_standby = 1'b0;
    p6bc_bus_ctl_t bus_ctl = 5'h1F;
    logic [6:0] pin_in, pin_out, pin_oe, ext_level = 7'h55;
    int fail_count = 0, total_checks = 0;
    // clock, 20 ns period
    always #10 aclk = ~aclk;
    p6bc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mode_pins(mode_pins), .hw_standby_n(hw_standby_n), .sw_standby(sw_standby),
        .bus_ctl(bus_ctl), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .bus_request_n(bus_request_n), .wait_request_n(wait_request_n));
    p6bc_ext_model ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
    // verdict and end of run
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // compare seen against expected
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // give up on a hung handshake
    task hang(input int n);
        if (n >= 100)
        begin
            fail_count++;
            test_done();
        end
    endtask : hang
    // one write: address and data offered together, bready held until bvalid
    task axi_write(input logic [31:0] a, input logic [7:0] d);
        int n;
        logic aw_hit, w_hit;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        #1;
        n = 0;
        while ((awvalid || wvalid) && n < 100)
        begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            @(posedge aclk);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
            n++;
            #1;
        end
        hang(n);
        n = 0;
        while (bready && n < 100)
        begin
            @(negedge aclk);
            resp = bresp;
            aw_hit = bvalid;
            @(posedge aclk);
            if (aw_hit)
                bready <= 1'b0;
            n++;
            #1;
        end
        hang(n);
    endtask : axi_write
    // one read: rready held until rvalid
    task axi_read(input logic [31:0] a);
        int n;
        logic hit;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        #1;
        n = 0;
        while (rready && n < 100)
        begin
            @(negedge aclk);
            if (arvalid && arready)
                hit = 1'b1;
            else
                hit = 1'b0;
            if (rvalid)
            begin
                resp = rresp;
                rd_word = rdata;
                check("arready with rvalid", arready, 1'b0);
            end
            @(posedge aclk);
            if (hit)
                arvalid <= 1'b0;
            if (rvalid && !arvalid)
                rready <= 1'b0;
            n++;
            #1;
        end
        hang(n);
    endtask : axi_read
    // read a register and compare its whole word and an okay response
    task rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        axi_read(a);
        check(name, rd_word, exp);
        check("read resp", {30'h0, resp}, {30'h0, `P6BC_RESP_OKAY});
    endtask : rd_chk
    // reset with a chosen mode strap
    task do_reset(input logic [2:0] m);
        @(posedge aclk);
        mode_pins <= m;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset
    // let pins and synchronisers settle, sample mid-cycle
    task settle;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
    endtask : settle
    // main sequence
    initial
    begin
        // single-chip mode: plain port
        do_reset(3'h7);
        settle();
        check("oe after reset", pin_oe, 7'h00);
        rd_chk("ddr read", A_DDR, 32'hFF);
        rd_chk("dr inputs", A_DR, 32'hD5);
        axi_write(A_DDR, 8'h0F);
        axi_write(A_DR, 8'h7A);
        settle();
        check("oe by dir", pin_oe, 7'h0F);
        check("out by data", pin_out[3:0], 4'hA);
        rd_chk("dr mixed", A_DR, 32'hDA);
        rd_chk("ddr still ones", A_DDR, 32'hFF);
        @(posedge aclk);
        sw_standby <= 1'b1;
        ext_level <= 7'h2A;
        settle();
        check("sw standby oe", pin_oe, 7'h0F);
        check("sw standby out", pin_out[3:0], 4'hA);
        @(posedge aclk);
        sw_standby <= 1'b0;
        hw_standby_n <= 1'b0;
        settle();
        check("hw standby oe", pin_oe, 7'h00);
        @(posedge aclk);
        hw_standby_n <= 1'b1;
        settle();
        check("oe after hw standby", pin_oe, 7'h00);
        rd_chk("dr after hw standby", A_DR, 32'hAA);
        axi_read(A_DDR + 32'h4);
        check("unmapped read resp", {30'h0, resp}, {30'h0, `P6BC_RESP_DECERR});
        axi_write(A_DDR + 32'h4, 8'h11);
        check("unmapped write resp", {30'h0, resp}, {30'h0, `P6BC_RESP_DECERR});
        $display("test single_chip done");
        // expanded mode: strobes, bus release, wait pin
        @(posedge aclk);
        bus_ctl <= 5'b10100;
        ext_level <= 7'h7C;
        do_reset(3'h1);
        settle();
        check("strobe oe", pin_oe, 7'h78);
        check("strobe out", pin_out[6:3], 4'hA);
        axi_write(A_DDR, 8'h07);
        axi_write(A_DR, 8'h05);
        settle();
        check("free pins oe", pin_oe, 7'h7F);
        check("free pins out", pin_out[2:0], 3'h5);
        check("no wait", wait_request_n, 1'b1);
        axi_write(A_DDR, 8'h06);
        axi_write(A_BRC, 8'h01);
        settle();
        check("release oe", pin_oe, 7'h7C);
        check("grant out", pin_out[2], 1'b0);
        check("request in", bus_request_n, 1'b0);
        axi_write(A_BRC, 8'h00);
        settle();
        check("release off oe", pin_oe, 7'h7E);
        check("request idle", bus_request_n, 1'b1);
        axi_write(A_DDR, 8'h00);
        axi_write(A_WCE, 8'hFE);
        settle();
        check("wait by enables", wait_request_n, 1'b0);
        axi_write(A_WCE, 8'hFF);
        axi_write(A_WCR, 8'h02);
        settle();
        check("wait by mode bit", wait_request_n, 1'b0);
        axi_write(A_WCR, 8'h00);
        axi_write(A_DDR, 8'h01);
        settle();
        check("wait released", wait_request_n, 1'b1);
        check("pin0 output", pin_oe, 7'h79);
        $display("test expanded done");
        test_done();
    end
endmodule : tb_top
